//--- core/tcv_defines.svh
/*
   Offsets, field positions, reset values and codes of the timer
   capture/compare control and vector block.
   Assumes inclusion by bare name from every design file that uses its macros.
*/
`ifndef TCV_DEFINES_SVH
`define TCV_DEFINES_SVH
`define TCV_NCH        7
`define TCV_IDX_VEC    4'h7
`define TCV_IDX_OVF    4'h8
`define TCV_IDX_STAT   4'h9
`define TCV_IDX_MASK   4'ha
`define TCV_CM_HI      15
`define TCV_CM_LO      14
`define TCV_IS_HI      13
`define TCV_IS_LO      12
`define TCV_CSEL       8
`define TCV_MODE_HI    7
`define TCV_MODE_LO    5
`define TCV_IE         4
`define TCV_RDBK       3
`define TCV_DOUT       2
`define TCV_OVR        1
`define TCV_FLG        0
`define TCV_OVF_FLG    0
`define TCV_OVF_IE     1
`define TCV_CTL_RST    16'h0000
`define TCV_CTL_WMASK  16'hfff7
`define TCV_VEC_NONE   4'h0
`define TCV_VEC_OVF    4'he
`define TCV_BUS_LAT    1
`endif

//--- core/tcv_pkg.sv
/*
   Types of the timer capture/compare control and vector block.
   Assumes nothing of its surroundings.
*/
package tcv_pkg;
   typedef enum logic [2:0] {
      TCV_OM_BIT, TCV_OM_SET, TCV_OM_TOG_RST, TCV_OM_SET_RST,
      TCV_OM_TOG, TCV_OM_RST, TCV_OM_TOG_SET, TCV_OM_RST_SET
   } tcv_outmode_t;

   typedef struct packed {
      logic [2:0] a_sy;
      logic [2:0] b_sy;
      logic       a_f;
      logic       b_f;
      logic       in_prev;
      logic       out;
   } tcv_chan_st_t;

   typedef struct packed {
      logic [6:0][15:0] ctl;
      logic [1:0]       ovf;
      logic [7:0]       stat;
      logic [7:0]       mask;
      logic             wreq;
      logic [15:0]      rdata;
      logic [3:0]       code;
      logic             irq;
   } tcv_top_st_t;
endpackage : tcv_pkg

//--- core/tcv_chan_if.sv
/*
   Carrier between the register file and one channel unit.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface tcv_chan_if;
   logic [15:0] ctl;
   logic        eq;
   logic        eq0;
   logic        out;
   logic        readback;
   logic        evt;
   modport regs (output ctl, eq, eq0, input out, readback, evt);
   modport chan (input ctl, eq, eq0, output out, readback, evt);
endinterface : tcv_chan_if

//--- core/tcv_vector.sv
/*
   Priority encoder of pending enabled sources into a vector code.
   Assumes pend_i bit 0..5 are channels 1..6, bit 6 the overflow.
*/
`timescale 1ns/1ns
`include "tcv_defines.svh"
module tcv_vector (
   input  wire logic       clock_i,
   input  wire logic       resetn_i,
   input  wire logic [6:0] pend_i,
   output logic      [3:0] code_o
);
   // ********************
   // Encoder
   // ********************
   function automatic logic [3:0] tcv_prio(input logic [6:0] p);
      tcv_prio = `TCV_VEC_NONE;
      for (int i = 6; i >= 0; i--) begin
         if (p[i]) begin
            tcv_prio = 4'((i + 1) * 2);
         end
      end
   endfunction : tcv_prio

   assign code_o = tcv_prio(pend_i);

   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   AST_VEC_IDLE: assert property (pend_i == 7'h00 |-> code_o == 4'h0)
      else $error("Vector not zero while idle");
   AST_VEC_EVEN: assert property (!code_o[0])
      else $error("Vector bit 0 set");
   AST_VEC_TOP: assert property (pend_i[0] |-> code_o == 4'h2)
      else $error("Channel 1 not reported first");
   AST_VEC_LOW: assert property (pend_i == 7'h40 |-> code_o == 4'he)
      else $error("Overflow alone not reported");
endmodule : tcv_vector

//--- core/tcv_channel.sv
/*
   Output unit and capture input path of one channel.
   Assumes equal pulses on the same clock; capture pins asynchronous.
*/
`timescale 1ns/1ns
`include "tcv_defines.svh"
module tcv_channel (
   input  wire logic clock_i,
   input  wire logic resetn_i,
   input  wire logic capin_a_i,
   input  wire logic capin_b_i,
   tcv_chan_if.chan  ch
);
   tcv_pkg::tcv_chan_st_t s_r;
   tcv_pkg::tcv_chan_st_t s_nxt;
   tcv_pkg::tcv_outmode_t mode;
   logic [1:0]            cm;
   logic                  sel;
   logic                  edge_hit;

   assign mode = tcv_pkg::tcv_outmode_t'(ch.ctl[`TCV_MODE_HI:`TCV_MODE_LO]);
   assign cm = ch.ctl[`TCV_CM_HI:`TCV_CM_LO];
   assign edge_hit = (cm[0] & sel & ~s_r.in_prev)
                   | (cm[1] & ~sel & s_r.in_prev);
   assign ch.evt = ch.ctl[`TCV_CSEL] ? edge_hit : ch.eq;
   assign ch.out = s_r.out;
   assign ch.readback = sel;

   always_comb begin
      case (ch.ctl[`TCV_IS_HI:`TCV_IS_LO])
         2'h0: sel = s_r.a_f;
         2'h1: sel = s_r.b_f;
         2'h2: sel = 1'h0;
         default: sel = 1'h1;
      endcase
   end

   // ********************
   // Next state
   // ********************
   always_comb begin
      s_nxt = s_r;
      s_nxt.a_sy = {s_r.a_sy[1:0], capin_a_i};
      s_nxt.b_sy = {s_r.b_sy[1:0], capin_b_i};
      if (s_r.a_sy[1] == s_r.a_sy[2]) begin
         s_nxt.a_f = s_r.a_sy[2];
      end
      if (s_r.b_sy[1] == s_r.b_sy[2]) begin
         s_nxt.b_f = s_r.b_sy[2];
      end
      s_nxt.in_prev = sel;
      case (mode)
         tcv_pkg::TCV_OM_BIT: s_nxt.out = ch.ctl[`TCV_DOUT];
         tcv_pkg::TCV_OM_SET: if (ch.eq) s_nxt.out = 1'h1;
         tcv_pkg::TCV_OM_TOG_RST:
            if (ch.eq0) s_nxt.out = 1'h0;
            else if (ch.eq) s_nxt.out = ~s_r.out;
         tcv_pkg::TCV_OM_SET_RST:
            if (ch.eq0) s_nxt.out = 1'h0;
            else if (ch.eq) s_nxt.out = 1'h1;
         tcv_pkg::TCV_OM_TOG: if (ch.eq) s_nxt.out = ~s_r.out;
         tcv_pkg::TCV_OM_RST: if (ch.eq) s_nxt.out = 1'h0;
         tcv_pkg::TCV_OM_TOG_SET:
            if (ch.eq0) s_nxt.out = 1'h1;
            else if (ch.eq) s_nxt.out = ~s_r.out;
         default:
            if (ch.eq0) s_nxt.out = 1'h1;
            else if (ch.eq) s_nxt.out = 1'h0;
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   sequence a_steady;
      (ch.ctl[`TCV_IS_HI:`TCV_IS_LO] == 2'h0 && capin_a_i)[*6];
   endsequence

   AST_MODE0: assert property (mode == tcv_pkg::TCV_OM_BIT
      |=> ch.out == $past(ch.ctl[`TCV_DOUT]))
      else $error("Mode 0 output does not follow the bit");
   AST_SET: assert property (mode == tcv_pkg::TCV_OM_SET && ch.eq
      |=> ch.out)
      else $error("Set mode did not set");
   AST_TOG: assert property (mode == tcv_pkg::TCV_OM_TOG && ch.eq
      |=> ch.out != $past(ch.out))
      else $error("Toggle mode did not toggle");
   AST_SEL_A: assert property (a_steady |=> ch.readback)
      else $error("Input A not routed");
   AST_SEL_LOW: assert property (ch.ctl[`TCV_IS_HI:`TCV_IS_LO] == 2'h2
      |-> !ch.readback)
      else $error("Low select not low");
endmodule : tcv_channel

//--- core/tcv_top.sv
/*
   Capture/compare channel control registers, overflow flag, priority
   vector register and interrupt logic behind an Avalon-MM slave.
   Assumes the counter supplies same-clock equal pulses per channel
   and an overflow pulse; capture pins are asynchronous.
*/
`timescale 1ns/1ns
`include "tcv_defines.svh"
module tcv_top (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             irq_o,
   input  wire logic [6:0]  chan_equal_i,
   input  wire logic        ovf_event_i,
   input  wire logic [6:0]  capin_a_i,
   input  wire logic [6:0]  capin_b_i,
   output logic      [6:0]  chan_out_o
);
   // ********************
   // Declarations
   // ********************
   tcv_pkg::tcv_top_st_t s_r;
   tcv_pkg::tcv_top_st_t s_nxt;
   logic [6:0][15:0]     ctl_rd;
   logic [6:0]           evt;
   logic [6:0]           rdbk;
   logic [6:0]           pend;
   logic [3:0]           vec_code;
   logic                 req;
   logic                 first;
   logic                 take;
   logic                 wr_go;
   logic                 rd_go;
   logic [15:0]          wd;
   logic [15:0]          wm;
   logic [7:0]           wm8;

   // ********************
   // Bus strobes
   // ********************
   assign req   = avs_read_i | avs_write_i;
   assign first = req & s_r.wreq;
   assign take  = req & ~s_r.wreq;
   assign wr_go = avs_write_i & take;
   assign rd_go = avs_read_i & take;
   assign wd    = avs_writedata_i[15:0];
   assign wm    = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign wm8   = {8{avs_byteenable_i[0]}};

   assign avs_readdata_o    = {16'h0000, s_r.rdata};
   assign avs_waitrequest_o = s_r.wreq;
   assign irq_o             = s_r.irq;

   // ********************
   // Channels
   // ********************
   for (genvar g = 0; g < `TCV_NCH; g++) begin : g_ch
      tcv_chan_if cif ();
      assign ctl_rd[g] = {s_r.ctl[g][15:4], rdbk[g], s_r.ctl[g][2:0]};
      assign cif.ctl = s_r.ctl[g];
      assign cif.eq  = chan_equal_i[g];
      assign cif.eq0 = chan_equal_i[0];
      assign evt[g]  = cif.evt;
      assign rdbk[g] = cif.readback;
      assign chan_out_o[g] = cif.out;
      tcv_channel u_ch (
         .clock_i   (clock_i),
         .resetn_i  (resetn_i),
         .capin_a_i (capin_a_i[g]),
         .capin_b_i (capin_b_i[g]),
         .ch        (cif)
      );
   end

   // ********************
   // Vector
   // ********************
   for (genvar g = 1; g < `TCV_NCH; g++) begin : g_pend
      assign pend[g-1] = s_r.ctl[g][`TCV_FLG] & s_r.ctl[g][`TCV_IE];
   end
   assign pend[6] = s_r.ovf[`TCV_OVF_FLG] & s_r.ovf[`TCV_OVF_IE];

   tcv_vector u_vec (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .pend_i   (pend),
      .code_o   (vec_code)
   );

   // ********************
   // Read mux
   // ********************
   function automatic logic [15:0] rd_word(input logic [3:0] a);
      rd_word = 16'h0000;
      if (a < 4'(`TCV_NCH)) begin
         rd_word = ctl_rd[a[2:0]];
      end else if (a == `TCV_IDX_VEC) begin
         rd_word = {12'h000, vec_code};
      end else if (a == `TCV_IDX_OVF) begin
         rd_word = {14'h0000, s_r.ovf};
      end else if (a == `TCV_IDX_STAT) begin
         rd_word = {8'h00, s_r.stat};
      end else if (a == `TCV_IDX_MASK) begin
         rd_word = {8'h00, s_r.mask};
      end
   endfunction : rd_word

   // ********************
   // Next state
   // ********************
   always_comb begin
      s_nxt = s_r;
      s_nxt.wreq = ~first;
      if (first) begin
         s_nxt.rdata = rd_word(avs_address_i);
         s_nxt.code  = vec_code;
      end
      // Software writes and clears first, hardware sets after
      if (wr_go) begin
         for (int k = 0; k < `TCV_NCH; k++) begin
            if (avs_address_i == 4'(k)) begin
               s_nxt.ctl[k] = (s_r.ctl[k] & ~(wm & `TCV_CTL_WMASK))
                            | (wd & wm & `TCV_CTL_WMASK);
            end
         end
         if (avs_address_i == `TCV_IDX_OVF && avs_byteenable_i[0]) begin
            s_nxt.ovf = wd[1:0];
         end
         if (avs_address_i == `TCV_IDX_STAT) begin
            s_nxt.stat = s_r.stat & ~(wd[7:0] & wm8);
         end
         if (avs_address_i == `TCV_IDX_MASK && avs_byteenable_i[0]) begin
            s_nxt.mask = wd[7:0];
         end
      end
      if (rd_go && avs_address_i == `TCV_IDX_VEC) begin
         if (s_r.code == `TCV_VEC_OVF) begin
            s_nxt.ovf[`TCV_OVF_FLG] = 1'h0;
         end
         for (int k = 1; k < `TCV_NCH; k++) begin
            if (s_r.code == 4'(k * 2)) begin
               s_nxt.ctl[k][`TCV_FLG] = 1'h0;
            end
         end
      end
      for (int k = 0; k < `TCV_NCH; k++) begin
         if (evt[k]) begin
            if (s_r.ctl[k][`TCV_CSEL] && s_r.ctl[k][`TCV_FLG]) begin
               s_nxt.ctl[k][`TCV_OVR] = 1'h1;
            end
            s_nxt.ctl[k][`TCV_FLG] = 1'h1;
            s_nxt.stat[k] = 1'h1;
         end
      end
      if (ovf_event_i) begin
         s_nxt.ovf[`TCV_OVF_FLG] = 1'h1;
         s_nxt.stat[7] = 1'h1;
      end
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
   end

   // ********************
   // State register
   // ********************
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
         s_r.ctl <= {`TCV_NCH{`TCV_CTL_RST}};
         s_r.code <= `TCV_VEC_NONE;
         s_r.wreq <= 1'h1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   sequence bus_start;
      req && s_r.wreq;
   endsequence

   sequence bus_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence

   sequence vec_read_ch1;
      avs_read_i && avs_address_i == `TCV_IDX_VEC && !s_r.wreq
         && s_r.code == 4'h2 && !evt[1];
   endsequence

   sequence vec_read_ovf;
      avs_read_i && avs_address_i == `TCV_IDX_VEC && !s_r.wreq
         && s_r.code == 4'he && !ovf_event_i;
   endsequence

   AST_BUS_ACK: assert property (bus_start |=> bus_answer)
      else $error("Bus answer not one cycle after request");
   AST_IE_OFF: assert property (s_r.ctl[1][`TCV_IE] == 1'h0
      |-> vec_code != 4'h2)
      else $error("Disabled channel 1 reported");
   AST_IE_ON: assert property (s_r.ctl[1][`TCV_IE]
      && s_r.ctl[1][`TCV_FLG] |-> vec_code == 4'h2)
      else $error("Enabled channel 1 not reported");
   AST_PRIO_OVF: assert property (pend[6] && pend[5]
      && pend[4:0] == 5'h00 |-> vec_code == 4'hc)
      else $error("Overflow beat channel 6");
   AST_VEC_CLR: assert property (vec_read_ch1
      |=> !s_r.ctl[1][`TCV_FLG])
      else $error("Vector read left channel 1 flag");
   AST_VEC_CLR_OVF: assert property (vec_read_ovf
      |=> !s_r.ovf[`TCV_OVF_FLG])
      else $error("Vector read left overflow flag");
   AST_IRQ: assert property (irq_o == |(s_r.stat & s_r.mask))
      else $error("Interrupt does not match status and mask");
   AST_STICKY: assert property (evt[2]
      |=> s_r.stat[2] && s_r.ctl[2][`TCV_FLG])
      else $error("Channel event not recorded");
endmodule : tcv_top

//--- tb/tcv_top_test.sv
/*
   Self-checking bench of the capture/compare control and vector block.
   Assumes the design files under core/ are compiled before it.
*/
`timescale 1ns/1ns
`include "tcv_defines.svh"
`define TCV_CHK(got, exp) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); \
   end \
end
module tcv_top_test;
   logic        clock_i;
   logic        resetn_i;
   logic [3:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        irq_o;
   logic [6:0]  chan_equal_i;
   logic        ovf_event_i;
   logic [6:0]  capin_a_i;
   logic [6:0]  capin_b_i;
   logic [6:0]  chan_out_o;
   int          n_errors;
   int          check_count;

   tcv_top tcv_top_i (
      .clock_i           (clock_i),
      .resetn_i          (resetn_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .irq_o             (irq_o),
      .chan_equal_i      (chan_equal_i),
      .ovf_event_i       (ovf_event_i),
      .capin_a_i         (capin_a_i),
      .capin_b_i         (capin_b_i),
      .chan_out_o        (chan_out_o)
   );

   // ********************************
   // Bus and stimulus tasks
   // ********************************
   task automatic bus_req(input logic [3:0] a, input logic wr,
                          input logic [15:0] wd, output logic [15:0] rd);
      int n;
      n = 0;
      @(posedge clock_i);
      avs_address_i   <= a;
      avs_read_i      <= ~wr;
      avs_write_i     <= wr;
      avs_writedata_i <= {16'h0000, wd};
      do begin
         @(posedge clock_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) n_errors++;
      rd = avs_readdata_o[15:0];
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask : bus_req

   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] x;
      bus_req(a, 1'b1, d, x);
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
      bus_req(a, 1'b0, 16'h0000, d);
   endtask : bus_rd

   task automatic pulse(input logic [6:0] eq, input logic ov);
      @(posedge clock_i);
      chan_equal_i <= eq;
      ovf_event_i  <= ov;
      @(posedge clock_i);
      chan_equal_i <= 7'h00;
      ovf_event_i  <= 1'b0;
      repeat (2) @(negedge clock_i);
   endtask : pulse

   // ********************************
   // Scenarios
   // ********************************
   task automatic test_reset;
      logic [15:0] d;
      for (int i = 0; i < 7; i++) begin
         bus_rd(i[3:0], d);
         `TCV_CHK(d, 16'h0000)
      end
      bus_rd(`TCV_IDX_VEC, d);
      `TCV_CHK(d, 16'h0000)
      bus_wr(4'hb, 16'hffff);
      bus_rd(4'hb, d);
      `TCV_CHK(d, 16'h0000)
      `TCV_CHK(irq_o, 1'b0)
   endtask : test_reset

   task automatic test_insel;
      logic [15:0] d;
      logic        e;
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 2; k++) begin
            capin_a_i <= {7{k[0]}};
            capin_b_i <= {7{~k[0]}};
            bus_wr(4'h1, {2'b00, s[1:0], 12'h000});
            repeat (8) @(posedge clock_i);
            bus_rd(4'h1, d);
            e = (s == 0) ? k[0] : (s == 1) ? ~k[0] : (s == 3);
            `TCV_CHK(d, {2'b00, s[1:0], 8'h00, e, 3'b000})
         end
      end
      capin_a_i <= 7'h00;
      capin_b_i <= 7'h00;
      bus_wr(4'h1, 16'h0000);
   endtask : test_insel

   task automatic test_direct;
      bus_wr(4'h2, 16'h0004);
      repeat (2) @(negedge clock_i);
      `TCV_CHK(chan_out_o, 7'h04)
      bus_wr(4'h2, 16'h0000);
      repeat (2) @(negedge clock_i);
      `TCV_CHK(chan_out_o, 7'h00)
   endtask : test_direct

   task automatic test_modes;
      logic [7:0] ini;
      logic [7:0] aeq;
      logic [7:0] aeq0;
      ini  = 8'b1110_0000;
      aeq  = 8'b0001_1110;
      aeq0 = 8'b1101_0010;
      for (int m = 1; m < 8; m++) begin
         bus_wr(4'h3, {13'h0000, ini[m], 2'b00});
         bus_wr(4'h3, {8'h00, m[2:0], 2'b00, ini[m], 2'b00});
         pulse(7'h08, 1'b0);
         `TCV_CHK(chan_out_o[3], aeq[m])
         pulse(7'h01, 1'b0);
         `TCV_CHK(chan_out_o[3], aeq0[m])
      end
      bus_wr(4'h3, 16'h0000);
      bus_wr(4'h0, 16'h0000);
   endtask : test_modes

   task automatic test_vector;
      logic [15:0] d;
      logic [15:0] ev [6];
      ev = '{16'h0002, 16'h0004, 16'h000a, 16'h000c, 16'h000e, 16'h0000};
      bus_wr(`TCV_IDX_STAT, 16'h00ff);
      for (int i = 1; i < 7; i++) begin
         bus_wr(i[3:0], (i == 4) ? 16'h0000 : 16'h0010);
      end
      bus_wr(`TCV_IDX_OVF, 16'h0002);
      pulse(7'h10, 1'b0);
      bus_rd(`TCV_IDX_VEC, d);
      `TCV_CHK(d, 16'h0000)
      pulse(7'h66, 1'b1);
      for (int i = 0; i < 6; i++) begin
         bus_rd(`TCV_IDX_VEC, d);
         `TCV_CHK(d, ev[i])
      end
      bus_rd(4'h1, d);
      `TCV_CHK(d, 16'h0010)
      bus_rd(4'h4, d);
      `TCV_CHK(d, 16'h0001)
      bus_rd(`TCV_IDX_OVF, d);
      `TCV_CHK(d, 16'h0002)
   endtask : test_vector

   task automatic test_irq;
      logic [15:0] d;
      bus_wr(`TCV_IDX_STAT, 16'h00ff);
      bus_wr(`TCV_IDX_MASK, 16'h0004);
      pulse(7'h02, 1'b0);
      `TCV_CHK(irq_o, 1'b0)
      pulse(7'h04, 1'b0);
      `TCV_CHK(irq_o, 1'b1)
      bus_rd(`TCV_IDX_STAT, d);
      `TCV_CHK(d, 16'h0006)
      bus_wr(`TCV_IDX_STAT, 16'h0004);
      repeat (2) @(negedge clock_i);
      `TCV_CHK(irq_o, 1'b0)
      bus_rd(`TCV_IDX_STAT, d);
      `TCV_CHK(d, 16'h0002)
      bus_wr(`TCV_IDX_MASK, 16'h0080);
      bus_rd(`TCV_IDX_MASK, d);
      `TCV_CHK(d, 16'h0080)
      pulse(7'h00, 1'b1);
      `TCV_CHK(irq_o, 1'b1)
      bus_wr(`TCV_IDX_STAT, 16'h0080);
      repeat (2) @(negedge clock_i);
      `TCV_CHK(irq_o, 1'b0)
   endtask : test_irq

   task automatic test_capture;
      logic [15:0] d;
      bus_wr(4'h5, 16'h4100);
      capin_a_i <= 7'h20;
      repeat (8) @(posedge clock_i);
      bus_rd(4'h5, d);
      `TCV_CHK(d, 16'h4109)
      capin_a_i <= 7'h00;
      repeat (8) @(posedge clock_i);
      capin_a_i <= 7'h20;
      repeat (8) @(posedge clock_i);
      bus_rd(4'h5, d);
      `TCV_CHK(d, 16'h410b)
   endtask : test_capture

   // ********************************
   // Verdict, clock, watchdog, sequence
   // ********************************
   task automatic report_and_stop;
      if (n_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      n_errors++;
      report_and_stop;
   end

   initial begin
      n_errors         = 0;
      check_count      = 0;
      resetn_i         = 1'b0;
      avs_address_i    = 4'h0;
      avs_read_i       = 1'b0;
      avs_write_i      = 1'b0;
      avs_writedata_i  = 32'h0000_0000;
      avs_byteenable_i = 4'hf;
      chan_equal_i     = 7'h00;
      ovf_event_i      = 1'b0;
      capin_a_i        = 7'h00;
      capin_b_i        = 7'h00;
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'b1;
      test_reset;
      test_insel;
      test_direct;
      test_modes;
      test_vector;
      test_irq;
      test_capture;
      report_and_stop;
   end
endmodule : tcv_top_test
